// ---- adcsp_pkg.sv ----
package adcsp_pkg;
    localparam int ADCSP_BYTE_BITS = 8;
    localparam int ADCSP_RES_BITS = 10;
    localparam int ADCSP_WORD_BITS = 16;
    localparam int ADCSP_SUB_BITS = 2;
    localparam int ADCSP_LEAD_BITS = 4;
    localparam int ADCSP_CHANNELS = 16;
    localparam int ADCSP_SAR_CYCLES = 12;
    localparam logic [1:0] ADCSP_CLK_EXT = 2'h3;
    localparam logic [7:0] ADCSP_CONV_MASK = 8'h80;
    localparam logic [7:0] ADCSP_SETUP_MASK = 8'hC0;
    localparam logic [7:0] ADCSP_SETUP_CODE = 8'h40;
    localparam logic [7:0] ADCSP_TEMP_BIT = 8'h01;
    typedef enum logic [1:0] {ADCSP_IDLE, ADCSP_CONV, ADCSP_DONE}
        adcsp_state_type;
endpackage

// ---- adcsp_if.sv ----
`timescale 1ns/1ps
interface adcsp_if;
    import adcsp_pkg::*;
    logic start;
    logic [3:0] chan;
    logic temp;
    logic bipolar;
    logic diff;
    logic busy;
    logic done;
    logic [ADCSP_RES_BITS-1:0] result;
    modport ctrl (output start, chan, temp, bipolar, diff,
        input busy, done, result);
    modport conv (input start, chan, temp, bipolar, diff,
        output busy, done, result);
endinterface

// ---- adcsp_sar.sv ----
`timescale 1ns/1ps
module adcsp_sar
    import adcsp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // comparator and conversion link
    input wire logic comp_hi,
    adcsp_if.conv link
);
    adcsp_state_type state_reg, state_next;
    logic [ADCSP_RES_BITS-1:0] sar_reg, sar_next;
    logic [ADCSP_RES_BITS-1:0] bit_reg, bit_next;
    logic done_reg, done_next;
    logic fmt_reg, fmt_next;

    always_comb begin
        state_next = state_reg;
        sar_next = sar_reg;
        bit_next = bit_reg;
        done_next = 1'b0;
        fmt_next = fmt_reg;
        case (state_reg)
            ADCSP_IDLE: begin
                if (link.start) begin
                    state_next = ADCSP_CONV;
                    bit_next = {1'b1, {(ADCSP_RES_BITS-1){1'b0}}};
                    sar_next = {1'b1, {(ADCSP_RES_BITS-1){1'b0}}};
                    fmt_next = link.temp | (link.diff & link.bipolar);
                end
            end
            ADCSP_CONV: begin
                // binary search one bit per cycle
                if (!comp_hi) begin
                    sar_next = sar_reg & ~bit_reg;
                end
                bit_next = bit_reg >> 1;
                if (bit_reg[0]) begin
                    state_next = ADCSP_DONE;
                end else begin
                    sar_next = sar_next | (bit_reg >> 1);
                end
            end
            default: begin
                // offset binary to two's complement by msb flip
                if (fmt_reg) begin
                    sar_next = sar_reg ^ {1'b1, {(ADCSP_RES_BITS-1){1'b0}}};
                end
                done_next = 1'b1;
                state_next = ADCSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ADCSP_IDLE;
            sar_reg <= '0;
            bit_reg <= '0;
            done_reg <= 1'b0;
            fmt_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            done_reg <= done_next;
            fmt_reg <= fmt_next;
        end
    end

    assign link.busy = (state_reg != ADCSP_IDLE);
    assign link.done = done_reg;
    assign link.result = sar_reg;
endmodule

// ---- adcsp_top.sv ----
`timescale 1ns/1ps
module adcsp_top
    import adcsp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // serial port pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic eoc_n,
    // shared pins
    input wire logic convert_request_n,
    output logic convert_pin_is_analog,
    output logic ref_neg_pin_is_analog,
    // analog front end
    input wire logic comp_hi,
    output logic [3:0] analog_inputs_sel,
    output logic analog_diff,
    output logic analog_temp
);
    adcsp_if link();

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] cs_s1_reg, sclk_s1_reg, din_s1_reg, cnv_s1_reg;
    logic cs_s_reg, sclk_s_reg, din_s_reg, cnv_s_reg;
    // the fourth stage holds the previous level for edge detection
    logic sclk_d_reg, cs_d_reg, cnv_d_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1_reg <= 2'h3;
            sclk_s1_reg <= 2'h0;
            din_s1_reg <= 2'h0;
            cnv_s1_reg <= 2'h3;
            cs_s_reg <= 1'b1;
            sclk_s_reg <= 1'b0;
            din_s_reg <= 1'b0;
            cnv_s_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            cnv_d_reg <= 1'b1;
        end else begin
            cs_s1_reg <= {cs_s1_reg[0], cs_n};
            sclk_s1_reg <= {sclk_s1_reg[0], sclk};
            din_s1_reg <= {din_s1_reg[0], din};
            cnv_s1_reg <= {cnv_s1_reg[0], convert_request_n};
            cs_s_reg <= cs_s1_reg[1];
            sclk_s_reg <= sclk_s1_reg[1];
            din_s_reg <= din_s1_reg[1];
            cnv_s_reg <= cnv_s1_reg[1];
            sclk_d_reg <= sclk_s_reg;
            cs_d_reg <= cs_s_reg;
            cnv_d_reg <= cnv_s_reg;
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cnv_fall;
    assign sclk_rise = sclk_s_reg & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s_reg & sclk_d_reg;
    assign cs_fall = ~cs_s_reg & cs_d_reg;
    assign cnv_fall = ~cnv_s_reg & cnv_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // command shifter and setup state
    logic [ADCSP_BYTE_BITS-1:0] sh_reg, sh_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [1:0] clkmode_reg, clkmode_next;
    logic [1:0] refsel_reg, refsel_next;
    logic [3:0] chan_reg, chan_next;
    logic temp_reg, temp_next, diff_reg, diff_next, bip_reg, bip_next;
    logic start_reg, start_next;
    logic [ADCSP_WORD_BITS-1:0] res_reg, res_next;
    logic [ADCSP_WORD_BITS-1:0] out_reg, out_next;
    logic have_reg, have_next;
    logic dout_reg, dout_next, oe_reg, oe_next, eoc_reg, eoc_next;
    logic [ADCSP_BYTE_BITS-1:0] byte_in;
    logic cmd_conv, cmd_setup;

    // a completed byte with bit 7 set is a conversion command, with bits 7:6 at 01 a setup command; any other byte is ignored
    assign byte_in = {sh_reg[ADCSP_BYTE_BITS-2:0], din_s_reg};
    assign cmd_conv = (byte_in & ADCSP_CONV_MASK) == ADCSP_CONV_MASK;
    assign cmd_setup = (byte_in & ADCSP_SETUP_MASK) == ADCSP_SETUP_CODE;

    always_comb begin
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        clkmode_next = clkmode_reg;
        refsel_next = refsel_reg;
        chan_next = chan_reg;
        temp_next = temp_reg;
        diff_next = diff_reg;
        bip_next = bip_reg;
        start_next = 1'b0;
        res_next = res_reg;
        out_next = out_reg;
        have_next = have_reg;
        eoc_next = eoc_reg;
        // select high holds the bit counter at zero
        if (cs_s_reg) begin
            cnt_next = '0;
        end else if (sclk_rise) begin
            sh_next = byte_in;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'(ADCSP_BYTE_BITS-1)) begin
                if (cmd_conv) begin
                    chan_next = byte_in[6:3];
                    temp_next = byte_in[0];
                    start_next = 1'b1;
                end else if (cmd_setup) begin
                    clkmode_next = byte_in[5:4];
                    refsel_next = byte_in[3:2];
                    diff_next = byte_in[1];
                    bip_next = byte_in[0] & byte_in[1];
                end
            end
        end
        // select fall loads the stored word, zero when none
        if (cs_fall) begin
            out_next = have_reg ? res_reg : '0;
            have_next = 1'b0;
        end else if (!cs_s_reg && sclk_fall) begin
            out_next = {out_reg[ADCSP_WORD_BITS-2:0], 1'b0};
        end
        if (link.done) begin
            res_next = {{ADCSP_LEAD_BITS{1'b0}}, link.result,
                {ADCSP_SUB_BITS{1'b0}}};
            have_next = 1'b1;
            eoc_next = 1'b0;
        end
        if (cs_fall || (cnv_fall && clkmode_reg != ADCSP_CLK_EXT &&
                refsel_reg[1] == 1'b0)) begin
            // a result landing with the clear keeps eoc_n low
            eoc_next = ~link.done;
            if (cnv_fall && !cs_fall) begin
                start_next = 1'b1;
            end
        end
        // externally clocked mode never signals end of conversion
        if (clkmode_reg == ADCSP_CLK_EXT) begin
            eoc_next = 1'b1;
        end
        // output stage, released whenever select is high
        oe_next = ~cs_s_reg;
        dout_next = ~cs_s_reg & out_next[ADCSP_WORD_BITS-1];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sh_reg <= '0;
            cnt_reg <= '0;
            clkmode_reg <= 2'h2;
            refsel_reg <= 2'h0;
            chan_reg <= '0;
            temp_reg <= 1'b0;
            diff_reg <= 1'b0;
            bip_reg <= 1'b0;
            start_reg <= 1'b0;
            res_reg <= '0;
            out_reg <= '0;
            have_reg <= 1'b0;
            dout_reg <= 1'b0;
            oe_reg <= 1'b0;
            eoc_reg <= 1'b1;
        end else begin
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            clkmode_reg <= clkmode_next;
            refsel_reg <= refsel_next;
            chan_reg <= chan_next;
            temp_reg <= temp_next;
            diff_reg <= diff_next;
            bip_reg <= bip_next;
            start_reg <= start_next;
            res_reg <= res_next;
            out_reg <= out_next;
            have_reg <= have_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            eoc_reg <= eoc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter
    // a start while the converter is busy is dropped
    assign link.start = start_reg & ~link.busy;
    assign link.chan = chan_reg;
    assign link.temp = temp_reg;
    assign link.diff = diff_reg;
    assign link.bipolar = bip_reg;

    adcsp_sar u_sar (
        .mclk(mclk),
        .rst_b(rst_b),
        .comp_hi(comp_hi),
        .link(link)
    );

    // shared pin roles, registered so the outputs come from flops
    logic cpa_reg, rpa_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cpa_reg <= 1'b0;
            rpa_reg <= 1'b0;
        end else begin
            cpa_reg <= refsel_reg[1];
            rpa_reg <= ~refsel_reg[0];
        end
    end

    assign dout = dout_reg;
    assign dout_oe = oe_reg;
    assign eoc_n = eoc_reg;
    assign convert_pin_is_analog = cpa_reg;
    assign ref_neg_pin_is_analog = rpa_reg;
    assign analog_inputs_sel = chan_reg;
    assign analog_diff = diff_reg;
    assign analog_temp = temp_reg;
endmodule

// ---- adcsp_top_chk.sv ----
`timescale 1ns/1ps
module adcsp_top_chk
    import adcsp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // serial port pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic eoc_n,
    // shared pins
    input wire logic convert_request_n,
    input wire logic convert_pin_is_analog,
    input wire logic ref_neg_pin_is_analog,
    // analog front end
    input wire logic comp_hi,
    input wire logic [3:0] analog_inputs_sel,
    input wire logic analog_diff,
    input wire logic analog_temp
);
    // cycles since the last serial clock fall and rise, and select low time
    logic sclk_reg, sclk_next;
    logic [4:0] fall_reg, fall_next, rise_reg, rise_next, csl_reg, csl_next;
    always_comb begin
        sclk_next = sclk;
        fall_next = fall_reg + {4'h0, fall_reg != 5'h1F};
        rise_next = rise_reg + {4'h0, rise_reg != 5'h1F};
        csl_next = cs_n ? 5'h00 : csl_reg + {4'h0, csl_reg != 5'h1F};
        if (sclk_reg && !sclk) fall_next = 5'h00;
        if (!sclk_reg && sclk) rise_next = 5'h00;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_reg <= 1'b0;
            fall_reg <= 5'h1F;
            rise_reg <= 5'h1F;
            csl_reg <= 5'h00;
        end else begin
            sclk_reg <= sclk_next;
            fall_reg <= fall_next;
            rise_reg <= rise_next;
            csl_reg <= csl_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_cs_idle;
        cs_n [*5];
    endsequence
    a_dout_released: assert property (s_cs_idle |-> !dout_oe)
        else $error("dout driven while deselected");
    a_dout_quiet: assert property (!dout_oe |-> !dout)
        else $error("dout not zero while released");
    a_dout_on_fall: assert property (dout_oe && csl_reg > 5'h0C &&
        $changed(dout) |-> fall_reg inside {[1:8]})
        else $error("dout changed away from a serial clock fall");
    a_eoc_on_select: assert property ($fell(cs_n) |-> ##[1:5] eoc_n)
        else $error("eoc_n not raised by select");
    a_eoc_on_request: assert property ($fell(convert_request_n) &&
        !convert_pin_is_analog |-> ##[1:5] eoc_n)
        else $error("eoc_n not raised by convert request");
    a_eoc_after_sar: assert property ($fell(eoc_n) |-> rise_reg >= 5'h0E)
        else $error("eoc_n fell before a conversion could end");
    a_sel_held: assert property (s_cs_idle |-> $stable(analog_inputs_sel)
        && $stable(analog_diff) && $stable(analog_temp))
        else $error("analog select changed while deselected");
    a_pins_held: assert property (s_cs_idle |->
        $stable(convert_pin_is_analog) && $stable(ref_neg_pin_is_analog))
        else $error("shared pin role changed while deselected");
endmodule
bind adcsp_top adcsp_top_chk u_chk(.mclk, .rst_b, .cs_n, .sclk, .din,
    .dout, .dout_oe, .eoc_n, .convert_request_n, .convert_pin_is_analog,
    .ref_neg_pin_is_analog, .comp_hi, .analog_inputs_sel, .analog_diff,
    .analog_temp);

// ---- adcsp_master.sv ----
`timescale 1ns/1ps
module adcsp_master
(
    // clock
    mclk,
    // serial pins
    cs_n,
    sclk,
    din,
    dout,
    dout_oe
);
    input wire logic mclk;
    output logic cs_n;
    output logic sclk;
    output logic din;
    input wire logic dout;
    input wire logic dout_oe;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // clocks n bits; a released dout reads as unknown
    task automatic frame(input logic [7:0] cmd, input int n,
        input logic quiet, output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge mclk) cs_n <= quiet;
        repeat (8) @(negedge mclk);
        for (int i = 0; i < n; i++) begin
            din <= (i < 8) ? cmd[7 - i] : 1'b0;
            repeat (8) @(negedge mclk);
            rd = {rd[14:0], dout_oe ? dout : 1'bx};
            sclk <= 1'b1;
            repeat (8) @(negedge mclk);
            sclk <= 1'b0;
        end
        repeat (8) @(negedge mclk);
        cs_n <= 1'b1;
        repeat (8) @(negedge mclk);
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import adcsp_pkg::*;
    logic mclk, rst_b, cs_n, sclk, din, dout, dout_oe, eoc_n, comp_hi;
    logic convert_request_n, convert_pin_is_analog, ref_neg_pin_is_analog;
    logic analog_diff, analog_temp;
    logic [3:0] analog_inputs_sel;
    logic [15:0] rd;
    int n_mismatch = 0;
    int n_compared = 0;
    adcsp_top u_dut(.mclk, .rst_b, .cs_n, .sclk, .din, .dout, .dout_oe,
        .eoc_n, .convert_request_n, .convert_pin_is_analog,
        .ref_neg_pin_is_analog, .comp_hi, .analog_inputs_sel, .analog_diff,
        .analog_temp);
    adcsp_master u_master(.mclk, .cs_n, .sclk, .din, .dout, .dout_oe);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bit1(input string what, input logic exp, got);
        check(what, {15'h0, exp}, {15'h0, got});
    endtask
    task automatic wait_eoc;
        for (int i = 0; i < 100 && eoc_n !== 1'b0; i++) @(negedge mclk);
        bit1("eoc_n low", 1'b0, eoc_n);
    endtask
    task automatic t_convert(input logic [7:0] cmd, input logic [15:0] exp);
        u_master.frame(cmd, 8, 1'b0, rd);
        wait_eoc();
        u_master.frame(8'h00, 16, 1'b0, rd);
        check("result word", exp, rd);
        bit1("eoc_n after select", 1'b1, eoc_n);
    endtask
    task automatic t_quiet;
        logic [3:0] s;
        s = analog_inputs_sel;
        u_master.frame(8'hF8, 8, 1'b1, rd);
        repeat (40) @(negedge mclk);
        check("idle sel", {12'h0, s}, {12'h0, analog_inputs_sel});
        bit1("idle eoc_n", 1'b1, eoc_n);
        bit1("idle dout_oe", 1'b0, dout_oe);
    endtask
    task automatic t_pins;
        u_master.frame(8'h78, 8, 1'b0, rd);
        bit1("pin analog", 1'b1, convert_pin_is_analog);
        bit1("ref pin analog", 1'b1, ref_neg_pin_is_analog);
        u_master.frame(8'hA8, 8, 1'b0, rd);
        repeat (60) @(negedge mclk);
        bit1("eoc_n ext mode", 1'b1, eoc_n);
        u_master.frame(8'h00, 16, 1'b0, rd);
        u_master.frame(8'h64, 8, 1'b0, rd);
        bit1("pin request", 1'b0, convert_pin_is_analog);
        bit1("ref pin ref", 1'b0, ref_neg_pin_is_analog);
    endtask
    task automatic t_partial;
        u_master.frame(8'hFF, 4, 1'b0, rd);
        u_master.frame(8'h90, 8, 1'b0, rd);
        check("sel", 16'h0002, {12'h0, analog_inputs_sel});
        wait_eoc();
        convert_request_n <= 1'b0;
        repeat (4) @(negedge mclk);
        convert_request_n <= 1'b1;
        bit1("eoc_n on request", 1'b1, eoc_n);
        u_master.frame(8'h00, 16, 1'b0, rd);
    endtask
    task automatic t_range(input logic [7:0] su, input logic c,
        input logic [15:0] exp);
        u_master.frame(su, 8, 1'b0, rd);
        comp_hi <= c;
        t_convert(8'hA8, exp);
        bit1("diff", su[1], analog_diff);
    endtask
    task automatic t_sweep;
        for (int ch = 0; ch < 16; ch++) begin
            u_master.frame({1'b1, ch[3:0], 3'h0}, 8, 1'b0, rd);
            check("channel", 16'(ch), {12'h0, analog_inputs_sel});
            wait_eoc();
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        test_done();
    end
    initial begin
        rst_b = 1'b0;
        convert_request_n = 1'b1;
        comp_hi = 1'b1;
        repeat (10) @(negedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(negedge mclk);
        bit1("reset dout_oe", 1'b0, dout_oe);
        bit1("reset eoc_n", 1'b1, eoc_n);
        u_master.frame(8'h00, 16, 1'b0, rd);
        check("empty word", 16'h0000, rd);
        t_convert(8'hA8, 16'h0FFC);
        bit1("temp", 1'b0, analog_temp);
        t_convert(8'h81, 16'h07FC);
        bit1("temp set", 1'b1, analog_temp);
        t_quiet();
        t_pins();
        t_partial();
        t_range(8'h67, 1'b1, 16'h07FC);
        t_range(8'h67, 1'b0, 16'h0800);
        t_range(8'h62, 1'b1, 16'h0FFC);
        t_range(8'h61, 1'b0, 16'h0000);
        t_sweep();
        test_done();
    end
endmodule
